/* File: hdl/dps_port_host.sv */
// Module: host controller driving one port of the dual-port RAM
//
// Summary of operation
// - One master drives busy to the array
// - Never configure two masters per word
// - Hold address, enable before write strobe
// - Write zero requests, one releases
// - Confirm zero write by reading flag
`timescale 1ns/10ps
`default_nettype none
module dps_port_host #(
   parameter int SETUP_CYC = dps_pkg::SETUP_CYC,
   parameter int STROBE_CYC = dps_pkg::STROBE_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_req_valid,
   input wire dps_pkg::dps_req_t i_req,
   output logic o_req_ready,
   output logic o_done,
   output logic [dps_pkg::DATA_W-1:0] o_rdata,
   output logic o_token_owned,
   output logic o_write_blocked,
   output dps_pkg::dps_ctl_t o_ctl,
   output logic [dps_pkg::DATA_W-1:0] o_data,
   output logic o_data_oe_n,
   input wire logic [dps_pkg::DATA_W-1:0] i_data,
   input wire logic i_left_port_busy_signal_n
);
   import dps_pkg::*;

   // Refuse phase counts the timer cannot hold
   if (SETUP_CYC < 1 || SETUP_CYC >= (1 << CNT_W) ||
       STROBE_CYC < 1 || STROBE_CYC >= (1 << CNT_W)) begin : g_bad_counts
      $error("dps_port_host: phase counts out of range");
   end

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SETUP = 6'h02,
      ST_STROBE = 6'h04,
      ST_CAPTURE = 6'h08,
      ST_RECOVER = 6'h10,
      ST_DONE = 6'h20
   } dps_state_t;

   dps_state_t state_q;
   dps_req_t req_q;
   logic [1:0] din_sync1_busy_q;
   logic busy_sync_q;
   logic [DATA_W-1:0] din_meta_q;
   logic [DATA_W-1:0] din_sync_q;
   logic blocked_q;
   logic timer_load;
   logic [CNT_W-1:0] timer_count;
   logic timer_done;

   // Helper: is this request a write of either space
   function automatic logic dps_is_write(input dps_op_t op);
      dps_is_write = (op == DPS_OP_MEM_WR) || (op == DPS_OP_SEM_WR);
   endfunction : dps_is_write

   // Helper: is this request aimed at token space
   function automatic logic dps_is_sem(input dps_op_t op);
      dps_is_sem = (op == DPS_OP_SEM_RD) || (op == DPS_OP_SEM_WR);
   endfunction : dps_is_sem

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Two flops on busy and data bus inputs
   // busy from one master
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         din_sync1_busy_q <= 2'h3;
         din_meta_q <= '0;
         din_sync_q <= '0;
      end else begin
         din_sync1_busy_q <= {din_sync1_busy_q[0], i_left_port_busy_signal_n};
         din_meta_q <= i_data;
         din_sync_q <= din_meta_q;
      end
   end
   assign busy_sync_q = din_sync1_busy_q[1];

   // ------------------------------------------------------------
   // Phase timer
   // ------------------------------------------------------------
   dps_cycle_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_load(timer_load),
      .i_count(timer_count),
      .o_done(timer_done)
   );

   // Load timer on entering setup or strobe
   always_comb begin
      timer_load = 1'b0;
      timer_count = '0;
      if (state_q == ST_IDLE && i_req_valid) begin
         timer_load = 1'b1;
         timer_count = CNT_W'(SETUP_CYC);
      end else if (state_q == ST_SETUP && timer_done) begin
         timer_load = 1'b1;
         timer_count = CNT_W'(STROBE_CYC);
      end
   end

   // ------------------------------------------------------------
   // Access sequencer
   // ------------------------------------------------------------
   // setup before strobe
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_q <= ST_IDLE;
         req_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (i_req_valid) begin
                  req_q <= i_req;
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (timer_done) begin
                  state_q <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (timer_done) begin
                  state_q <= ST_CAPTURE;
               end
            end
            ST_CAPTURE: state_q <= ST_RECOVER;
            ST_RECOVER: state_q <= ST_DONE;
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Port pins
   // ------------------------------------------------------------
   // Drive control and address pins
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_ctl <= CTL_IDLE;
      end else if (state_q == ST_SETUP || state_q == ST_STROBE ||
                   state_q == ST_CAPTURE) begin
         o_ctl.chip_en_n <= dps_is_sem(req_q.op);
         o_ctl.token_space_select_n <= !dps_is_sem(req_q.op);
         o_ctl.addr <= dps_is_sem(req_q.op) ?
                       {{(ADDR_W-FLAG_IDX_W){1'b0}}, req_q.addr[FLAG_IDX_W-1:0]} :
                       req_q.addr;
         o_ctl.rd_wr_n <= !(dps_is_write(req_q.op) && state_q == ST_STROBE &&
                            !timer_done);
         o_ctl.out_en_n <= dps_is_write(req_q.op);
      end else begin
         o_ctl <= CTL_IDLE;
      end
   end

   // Drive data bus during writes
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_data <= '0;
         o_data_oe_n <= 1'b1;
      end else if (dps_is_write(req_q.op) &&
                   (state_q == ST_SETUP || state_q == ST_STROBE)) begin
         o_data <= dps_is_sem(req_q.op) ?
                   {{(DATA_W-1){1'b1}}, req_q.wdata[FLAG_BIT]} : req_q.wdata;
         o_data_oe_n <= 1'b0;
      end else begin
         o_data_oe_n <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Results
   // ------------------------------------------------------------
   // note busy low in strobe
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         blocked_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         blocked_q <= 1'b0;
      end else if (state_q == ST_STROBE && !busy_sync_q &&
                   req_q.op == DPS_OP_MEM_WR) begin
         blocked_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_rdata <= '0;
         o_token_owned <= 1'b0;
      end else if (state_q == ST_RECOVER && !dps_is_write(req_q.op)) begin
         o_rdata <= din_sync_q;
         if (req_q.op == DPS_OP_SEM_RD) begin
            o_token_owned <= !din_sync_q[FLAG_BIT];
         end
      end
   end

   // Handshake outputs
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_done <= 1'b0;
         o_req_ready <= 1'b0;
         o_write_blocked <= 1'b0;
      end else begin
         o_done <= (state_q == ST_RECOVER);
         o_req_ready <= (state_q == ST_IDLE) && !i_req_valid;
         if (state_q == ST_RECOVER) begin
            o_write_blocked <= blocked_q;
         end
      end
   end
endmodule : dps_port_host
`default_nettype wire

/* File: inc/dps_pkg.sv */
// Package: constants and types for the dual-port semaphore host controller
`default_nettype none
package dps_pkg;
   // ------------------------------------------------------------
   // Device geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int FLAG_IDX_W = 3;
   localparam int FLAG_COUNT = 8;
   localparam int FLAG_BIT = 0;
   // ------------------------------------------------------------
   // Timing, in ns, and derived cycle counts at 250 MHz
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int SETUP_NS = 20;
   localparam int STROBE_NS = 20;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // ------------------------------------------------------------
   // Request and pin groups
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      DPS_OP_MEM_RD = 2'h0,
      DPS_OP_MEM_WR = 2'h1,
      DPS_OP_SEM_RD = 2'h2,
      DPS_OP_SEM_WR = 2'h3
   } dps_op_t;
   typedef struct packed {
      dps_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dps_req_t;
   typedef struct packed {
      logic chip_en_n;
      logic token_space_select_n;
      logic rd_wr_n;
      logic out_en_n;
      logic [ADDR_W-1:0] addr;
   } dps_ctl_t;
   localparam dps_ctl_t CTL_IDLE = '{chip_en_n: 1'b1, token_space_select_n: 1'b1,
                                     rd_wr_n: 1'b1, out_en_n: 1'b1, addr: '0};
endpackage : dps_pkg
`default_nettype wire

/* File: hdl/dps_cycle_timer.sv */
// Module: down counter that times one phase of a port access
`timescale 1ns/10ps
`default_nettype none
module dps_cycle_timer #(
   parameter int CNT_W = 8
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_load,
   input wire logic [CNT_W-1:0] i_count,
   output logic o_done
);
   logic [CNT_W-1:0] cnt_q;

   // Refuse a counter with no bits
   if (CNT_W < 1) begin : g_bad_width
      $error("dps_cycle_timer: CNT_W must be at least 1");
   end

   // Count down after a load
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_q <= '0;
      end else if (i_load) begin
         cnt_q <= i_count;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
   // Done once the count has run out; no path back from the load
   assign o_done = (cnt_q == '0);
endmodule : dps_cycle_timer
`default_nettype wire

/* File: bench/dps_dev_model.sv */
// Behavioural dual-port device, right port reached by task
`timescale 1ns/10ps
`default_nettype none
module dps_dev_model (
   input wire logic i_clk,
   input wire dps_pkg::dps_ctl_t i_ctl,
   input wire logic [7:0] i_data,
   input wire logic i_busy_n,
   output logic [7:0] o_data
);
   logic own_l [8], own_r [8], req_l [8], req_r [8];
   logic [7:0] mem [16], sem_q, last_q, wd_q;
   logic wr_q, sel_q, rd_q;
   logic [3:0] ix_q;
   wire rd = !i_ctl.out_en_n && !(i_ctl.chip_en_n && i_ctl.token_space_select_n);
   wire wr = !i_ctl.rd_wr_n;
   task automatic settle(input int i);
      if (own_l[i] && req_l[i]) own_l[i] = 0;
      if (own_r[i] && req_r[i]) own_r[i] = 0;
      if (!own_l[i] && !own_r[i]) begin
         if (!req_l[i]) own_l[i] = 1;
         else if (!req_r[i]) own_r[i] = 1;
      end
   endtask : settle
   task automatic right_wr(input int i, input logic d);
      req_r[i] = d;
      settle(i);
   endtask : right_wr
   initial begin
      for (int i = 0; i < 8; i++) begin
         {own_l[i], own_r[i], req_l[i], req_r[i]} = 4'h3;
      end
      {wr_q, rd_q, last_q} = '0;
   end
   always @(posedge i_clk) begin
      wr_q <= wr;
      if (wr) begin
         ix_q <= i_ctl.addr[3:0];
         wd_q <= i_data;
         sel_q <= !i_ctl.token_space_select_n;
      end
      if (wr_q && !wr && sel_q) begin
         req_l[ix_q[2:0]] = wd_q[0];
         settle(ix_q[2:0]);
      end
      // slave busy input, flags gate nothing
      if (wr_q && !wr && !sel_q && i_busy_n) mem[ix_q] <= wd_q;
      rd_q <= rd;
      if (rd && !rd_q) sem_q <= {8{!own_l[i_ctl.addr[2:0]]}};
      if (rd) last_q <= o_data;
   end
   // Released bus shows inverse of last value
   assign o_data = !rd ? ~last_q : !i_ctl.token_space_select_n ? sem_q : mem[i_ctl.addr[3:0]];
endmodule : dps_dev_model
`default_nettype wire

/* File: bench/dps_port_host_assertions.sv */
// Pin and handshake assertions for the port host
`timescale 1ns/10ps
`default_nettype none
module dps_port_host_chk (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_req_valid,
   input wire dps_pkg::dps_req_t i_req,
   input wire logic o_req_ready,
   input wire logic o_done,
   input wire logic [dps_pkg::DATA_W-1:0] o_rdata,
   input wire logic o_token_owned,
   input wire logic o_write_blocked,
   input wire dps_pkg::dps_ctl_t o_ctl,
   input wire logic [dps_pkg::DATA_W-1:0] o_data,
   input wire logic o_data_oe_n,
   input wire logic [dps_pkg::DATA_W-1:0] i_data,
   input wire logic i_left_port_busy_signal_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire sel = !o_ctl.chip_en_n || !o_ctl.token_space_select_n;
   wire ssel = !o_ctl.token_space_select_n;
   property p_one_sel; !(!o_ctl.chip_en_n && ssel); endproperty
   a_one_sel: assert property (p_one_sel) else $error("both selects low");
   property p_done; o_done |=> !o_done; endproperty
   a_done: assert property (p_done) else $error("done too long");
   property p_lat; $fell(o_req_ready) |-> ##[6:24] o_done; endproperty
   a_lat: assert property (p_lat) else $error("no done in time");
   property p_idle; o_req_ready |-> !sel && o_data_oe_n; endproperty
   a_idle: assert property (p_idle) else $error("idle pins active");
   property p_setup; $fell(o_ctl.rd_wr_n) |-> $past(sel, 4) && $stable(o_ctl.addr); endproperty
   a_setup: assert property (p_setup) else $error("strobe too early");
   property p_strb; !o_ctl.rd_wr_n |-> sel && !o_data_oe_n && o_ctl.out_en_n; endproperty
   a_strb: assert property (p_strb) else $error("bad write pins");
   property p_saddr; ssel |-> o_ctl.addr[15:3] == 13'h0; endproperty
   a_saddr: assert property (p_saddr) else $error("flag address wide");
   property p_sdat; ssel && !o_data_oe_n |-> &o_data[7:1]; endproperty
   a_sdat: assert property (p_sdat) else $error("flag data upper");
   property p_own; o_done && i_req.op == dps_pkg::DPS_OP_SEM_RD |-> o_token_owned == !o_rdata[0];
   endproperty
   a_own: assert property (p_own) else $error("owned flag wrong");
endmodule : dps_port_host_chk
bind dps_port_host dps_port_host_chk dps_port_host_chk_inst (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done),
   .o_rdata(o_rdata), .o_token_owned(o_token_owned), .o_write_blocked(o_write_blocked),
   .o_ctl(o_ctl), .o_data(o_data), .o_data_oe_n(o_data_oe_n), .i_data(i_data),
   .i_left_port_busy_signal_n(i_left_port_busy_signal_n));
`default_nettype wire

/* File: bench/dps_port_host_test.sv */
// Self-checking testbench for the port host controller
`timescale 1ns/10ps
`default_nettype none
module dps_port_host_test;
   import dps_pkg::*;
   logic i_clk = 0, i_nrst = 0, req_valid = 0, busy_n = 1;
   logic ready, done, owned, blocked, h_oe_n;
   logic [7:0] rdata, h_data, m_data, bus;
   dps_req_t req = '0;
   dps_ctl_t ctl;
   int err_count = 0, cmp_count = 0;
   // Shared data bus
   assign bus = h_oe_n ? m_data : h_data;
   dps_port_host dps_port_host_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_req_valid(req_valid),
      .i_req(req), .o_req_ready(ready), .o_done(done), .o_rdata(rdata), .o_token_owned(owned),
      .o_write_blocked(blocked), .o_ctl(ctl), .o_data(h_data), .o_data_oe_n(h_oe_n),
      .i_data(bus), .i_left_port_busy_signal_n(busy_n));
   dps_dev_model dps_dev_model_inst (.i_clk(i_clk), .i_ctl(ctl), .i_data(h_data),
      .i_busy_n(busy_n), .o_data(m_data));
   initial begin
      forever #2 i_clk = ~i_clk;
   end
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One access, request held until done
   task automatic acc(input dps_op_t op, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge i_clk);
      req_valid = 1;
      req = '{op: op, addr: a, wdata: d};
      do begin
         @(negedge i_clk);
         n++;
      end while (done !== 1'b1 && n < 100);
      chk("done", {7'h0, done}, 8'h01);
      req_valid = 0;
   endtask : acc
   task automatic t_grant();
      acc(DPS_OP_SEM_WR, 16'hFFF5, 8'hFE);
      acc(DPS_OP_SEM_RD, 16'h0005, 8'h00);
      chk("flag", rdata, 8'h00);
      chk("owned", {7'h0, owned}, 8'h01);
      chk("other", {7'h0, dps_dev_model_inst.own_r[5]}, 8'h00);
      acc(DPS_OP_SEM_RD, 16'h0002, 8'h00);
      chk("flag2", rdata, 8'hFF);
      $display("test grant done");
   endtask : t_grant
   task automatic t_pass();
      dps_dev_model_inst.right_wr(5, 1'b0);
      acc(DPS_OP_SEM_RD, 16'h0005, 8'h00);
      chk("held", {7'h0, owned}, 8'h01);
      acc(DPS_OP_SEM_WR, 16'h0005, 8'h01);
      acc(DPS_OP_SEM_RD, 16'h0005, 8'h00);
      chk("passed", rdata, 8'hFF);
      acc(DPS_OP_SEM_WR, 16'h0005, 8'h00);
      acc(DPS_OP_SEM_RD, 16'h0005, 8'h00);
      chk("locked", {7'h0, owned}, 8'h00);
      dps_dev_model_inst.right_wr(5, 1'b1);
      acc(DPS_OP_SEM_RD, 16'h0005, 8'h00);
      chk("pending", {7'h0, owned}, 8'h01);
      acc(DPS_OP_SEM_WR, 16'h0005, 8'hFF);
      acc(DPS_OP_SEM_RD, 16'h0005, 8'h00);
      chk("free", rdata, 8'hFF);
      $display("test pass done");
   endtask : t_pass
   task automatic t_mem();
      acc(DPS_OP_MEM_WR, 16'h0003, 8'hA5);
      chk("unblocked", {7'h0, blocked}, 8'h00);
      busy_n = 0;
      acc(DPS_OP_MEM_WR, 16'h0003, 8'h5A);
      chk("blocked", {7'h0, blocked}, 8'h01);
      busy_n = 1;
      acc(DPS_OP_MEM_RD, 16'h0003, 8'h00);
      chk("mem", rdata, 8'hA5);
      $display("test mem done");
   endtask : t_mem
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (4) @(negedge i_clk);
      i_nrst = 1;
      t_grant();
      t_pass();
      t_mem();
      results();
   end
   // Watchdog
   initial begin
      #20000;
      err_count++;
      results();
   end
endmodule : dps_port_host_test
`default_nettype wire
